// >>> include/dopm_params.svh
// Constants for the digital output, PWM and output multiplexer block.
`ifndef DOPM_PARAMS_SVH
`define DOPM_PARAMS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define DOPM_NUM_CH        8
`define DOPM_SLAVE_CH      6
`define DOPM_ADDR_W        8
`define DOPM_DATA_W        32
`define DOPM_SRC_W         5
`define DOPM_CNT_W         4

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define DOPM_OFS_CTRL      8'h00
`define DOPM_OFS_DIRECT    8'h04
`define DOPM_OFS_MODE      8'h08
`define DOPM_OFS_PATH      8'h0c
`define DOPM_OFS_STATUS    8'h10
`define DOPM_OFS_SRC_BASE  8'h20
`define DOPM_SRC_STRIDE    8'h04
`define DOPM_OFS_FREQ_BASE 8'h40
`define DOPM_OFS_DUTY_BASE 8'h44
`define DOPM_PWM_STRIDE    8'h08

// ****************************************************************
// Field positions
// ****************************************************************
`define DOPM_CTRL_CNT_LSB  0
`define DOPM_CTRL_SLAVE    4
`define DOPM_ST_PWM_LSB    0
`define DOPM_ST_LVL_LSB    8
`define DOPM_ST_CNT_LSB    16

// ****************************************************************
// Reset values
// ****************************************************************
`define DOPM_RST_CNT       4'h8
`define DOPM_RST_DIRECT    8'hff
`define DOPM_RST_MODE      8'hff
`define DOPM_RST_PATH      16'h0000

// ****************************************************************
// Source select codes
// ****************************************************************
`define DOPM_SRC_DIRECT    5'h00
`define DOPM_SRC_PWM       5'h08
`define DOPM_SRC_SIGGEN    5'h10
`define DOPM_SRC_SENSOR    5'h18

// ****************************************************************
// Timing
// ****************************************************************
`define DOPM_CLK_HZ        250000000
`define DOPM_FREQ_MAX_HZ   100000
`define DOPM_FREQ_W        17
`define DOPM_PHASE_W       48
`define DOPM_DUTY_FULL     32'h8000_0000

`endif

// >>> include/dopm_pkg.sv
// Types shared by the digital output, PWM and output multiplexer block.
`include "dopm_params.svh"

package dopm_pkg;

  // Register port request from software.
  typedef struct packed {
    logic [`DOPM_ADDR_W-1:0] addr;
    logic [`DOPM_DATA_W-1:0] wdata;
    logic                    wr;
    logic                    rd;
  } dopm_bus_s;

  // Switch drives of one physical output; a high bit closes the switch.
  typedef struct packed {
    logic mode_switch;
    logic cutoff_switch;
    logic fast_low_switch;
    logic short_gnd;
    logic short_5v;
  } dopm_pin_s;

  // Path state of one output, in code order 0 to 3.
  typedef enum logic [1:0] {
    DOPM_PATH_OFF,
    DOPM_PATH_ON,
    DOPM_PATH_GND,
    DOPM_PATH_5V
  } dopm_path_e;

endpackage : dopm_pkg

// >>> rtl/dopm_pwm_chan.sv
// One active-high PWM generator with period-end update of its settings.
`timescale 1ns/1ns
`default_nettype none
`include "dopm_params.svh"

module dopm_pwm_chan (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Settings from the register file
  input  wire logic        chan_en,
  input  wire logic [31:0] freq_req,
  input  wire logic [31:0] duty_req,
  // Generator output
  output logic             pwm_out,
  output logic             period_end
);

  // Phase step per clock for 1 Hz, so that the accumulator wraps at the set rate.
  localparam logic [`DOPM_PHASE_W-1:0] NCO_K =
    `DOPM_PHASE_W'((64'h1 << `DOPM_PHASE_W) / 64'(`DOPM_CLK_HZ));
  localparam logic [31:0] FREQ_MAX = 32'(`DOPM_FREQ_MAX_HZ);

  logic [31:0]              freq_act_r;
  logic [31:0]              duty_act_r;
  logic [`DOPM_PHASE_W-1:0] phase_r;
  logic                     pwm_r;
  logic                     end_r;

  // ****************************************************************
  // Phase accumulator
  // ****************************************************************
  // Settings above the top rate are held at the top rate.
  wire [`DOPM_FREQ_W-1:0]  freq_clamp = (freq_act_r > FREQ_MAX) ?
                                        FREQ_MAX[`DOPM_FREQ_W-1:0] :
                                        freq_act_r[`DOPM_FREQ_W-1:0];
  wire [`DOPM_PHASE_W-1:0] phase_inc  = `DOPM_PHASE_W'(freq_clamp) * NCO_K;
  wire [`DOPM_PHASE_W:0]   phase_sum  = {1'b0, phase_r} + {1'b0, phase_inc};
  wire                     wrap       = phase_sum[`DOPM_PHASE_W];
  wire                     idle       = (freq_act_r == 32'h0000_0000) || !chan_en;
  // A stopped channel takes new settings at once, a running one only at its wrap.
  wire                     load       = wrap || idle;
  wire [`DOPM_PHASE_W-1:0] phase_nxt  = idle ? '0 : phase_sum[`DOPM_PHASE_W-1:0];

  // ****************************************************************
  // Duty compare
  // ****************************************************************
  // Duty is a fraction with 1.0 at the full value; zero and full never toggle.
  wire duty_full = (duty_act_r >= `DOPM_DUTY_FULL);
  wire pwm_nxt   = !idle && (duty_full ||
                   (phase_r[`DOPM_PHASE_W-1 -: 31] < duty_act_r[30:0]));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_act_r <= 32'h0000_0000;
      duty_act_r <= 32'h0000_0000;
      phase_r    <= '0;
      pwm_r      <= 1'b0;
      end_r      <= 1'b0;
    end else begin
      if (load) begin
        freq_act_r <= freq_req;
        duty_act_r <= duty_req;
      end
      phase_r <= phase_nxt;
      pwm_r   <= pwm_nxt;
      end_r   <= wrap && !idle;
    end
  end

  assign pwm_out    = pwm_r;
  assign period_end = end_r;

endmodule : dopm_pwm_chan

`default_nettype wire

// >>> rtl/dopm_top.sv
// Digital direct outputs, PWM generators and the output multiplexer with switch drives.
//
// What this block does
// - Direct value 0 drives the output low; 1 releases it high or open.
// - Eight PWM channels, pulses active high only, no polarity choice.
// - Each PWM channel keeps its own frequency and duty, independent of others.
// - New frequency and duty take effect at the end of a period, or at once on a stopped channel.
// - Frequency is a 32-bit unsigned value covering zero to 100 kHz.
// - Duty gives the high fraction, zero fully off to one fully on.
// - Channels in use configurable up to eight; slave variant limited to six.
// - Each output selects one source: direct, PWM, signal generator or sensor.
// - Selected source times the fast low switch while the cut-off is closed.
// - Closed fast switch gives the low phase, open switch the high phase.
// - Per-output mode picks internal 5 V pull-up or open collector.
// - Path state codes: 0 off, 1 connected, 2 ground, 3 to 5 V.
// - Path state drives only slow switches, static failure simulation, not signalling.
// - Source select and output mode can change while running.
// - Values are produced first, then the multiplexer picks what reaches pins.
`timescale 1ns/1ns
`default_nettype none
`include "dopm_params.svh"

module dopm_top (
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  // Register port
  input  wire dopm_pkg::dopm_bus_s            bus_i,
  output var  logic [`DOPM_DATA_W-1:0]        rdata,
  // Other internal sources
  input  wire logic [`DOPM_NUM_CH-1:0]        siggen_dig,
  input  wire logic                           sensor_sig,
  // Switch drives
  output var  dopm_pkg::dopm_pin_s [`DOPM_NUM_CH-1:0] pin_o
);

  import dopm_pkg::*;

  localparam int NCH = `DOPM_NUM_CH;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [`DOPM_CNT_W-1:0]     cnt_r;
  logic                       slave_r;
  logic [NCH-1:0]             direct_r;
  logic [NCH-1:0]             mode_r;
  logic [2*NCH-1:0]           path_r;
  logic [`DOPM_SRC_W-1:0]     src_r  [NCH];
  logic [31:0]                freq_r [NCH];
  logic [31:0]                duty_r [NCH];
  logic [`DOPM_DATA_W-1:0]    rdata_r;
  dopm_pin_s [NCH-1:0]        pin_r;

  wire [`DOPM_DATA_W-1:0] wd      = bus_i.wdata;
  wire                    wr_ctrl = bus_i.wr && (bus_i.addr == `DOPM_OFS_CTRL);
  wire                    wr_dir  = bus_i.wr && (bus_i.addr == `DOPM_OFS_DIRECT);
  wire                    wr_mode = bus_i.wr && (bus_i.addr == `DOPM_OFS_MODE);
  wire                    wr_path = bus_i.wr && (bus_i.addr == `DOPM_OFS_PATH);

  // All settings are plain registers, so software may rewrite them at any time.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r    <= `DOPM_RST_CNT;
      slave_r  <= 1'b0;
      direct_r <= `DOPM_RST_DIRECT;
      mode_r   <= `DOPM_RST_MODE;
      path_r   <= `DOPM_RST_PATH;
    end else begin
      if (wr_ctrl) begin
        cnt_r   <= wd[`DOPM_CTRL_CNT_LSB +: `DOPM_CNT_W];
        slave_r <= wd[`DOPM_CTRL_SLAVE];
      end
      if (wr_dir) begin
        direct_r <= wd[NCH-1:0];
      end
      if (wr_mode) begin
        mode_r <= wd[NCH-1:0];
      end
      if (wr_path) begin
        path_r <= wd[2*NCH-1:0];
      end
    end
  end

  // ****************************************************************
  // Channels in use
  // ****************************************************************
  localparam logic [`DOPM_CNT_W-1:0] MAX_MASTER = `DOPM_CNT_W'(`DOPM_NUM_CH);
  localparam logic [`DOPM_CNT_W-1:0] MAX_SLAVE  = `DOPM_CNT_W'(`DOPM_SLAVE_CH);

  wire [`DOPM_CNT_W-1:0] cnt_lim = slave_r ? MAX_SLAVE : MAX_MASTER;
  wire [`DOPM_CNT_W-1:0] cnt_eff = (cnt_r > cnt_lim) ? cnt_lim : cnt_r;

  logic [NCH-1:0]         chan_en;
  logic [NCH-1:0]         pwm_lvl;
  logic [NCH-1:0]         sel_lvl;
  logic [NCH-1:0]         dir_eff;
  logic [`DOPM_DATA_W-1:0] chan_rd [NCH];

  // ****************************************************************
  // Per-channel generators, registers and multiplexer
  // ****************************************************************
  genvar n;
  generate
    for (n = 0; n < NCH; n++) begin : g_ch
      localparam logic [`DOPM_ADDR_W-1:0] A_SRC  =
        `DOPM_ADDR_W'(`DOPM_OFS_SRC_BASE + `DOPM_SRC_STRIDE * n);
      localparam logic [`DOPM_ADDR_W-1:0] A_FREQ =
        `DOPM_ADDR_W'(`DOPM_OFS_FREQ_BASE + `DOPM_PWM_STRIDE * n);
      localparam logic [`DOPM_ADDR_W-1:0] A_DUTY =
        `DOPM_ADDR_W'(`DOPM_OFS_DUTY_BASE + `DOPM_PWM_STRIDE * n);
      localparam logic [`DOPM_SRC_W-1:0]  SRC_RST =
        `DOPM_SRC_W'(`DOPM_SRC_DIRECT + n);

      wire wr_src  = bus_i.wr && (bus_i.addr == A_SRC);
      wire wr_freq = bus_i.wr && (bus_i.addr == A_FREQ);
      wire wr_duty = bus_i.wr && (bus_i.addr == A_DUTY);

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          src_r[n]  <= SRC_RST;
          freq_r[n] <= 32'h0000_0000;
          duty_r[n] <= 32'h0000_0000;
        end else begin
          if (wr_src) begin
            src_r[n] <= wd[`DOPM_SRC_W-1:0];
          end
          if (wr_freq) begin
            freq_r[n] <= wd;
          end
          if (wr_duty) begin
            duty_r[n] <= wd;
          end
        end
      end

      assign chan_en[n] = (`DOPM_CNT_W'(n) < cnt_eff);
      // An unused channel releases its direct value and stops its generator.
      assign dir_eff[n] = direct_r[n] || !chan_en[n];

      dopm_pwm_chan u_pwm (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .chan_en    (chan_en[n]),
        .freq_req   (freq_r[n]),
        .duty_req   (duty_r[n]),
        .pwm_out    (pwm_lvl[n]),
        .period_end ()
      );

      // Source table; unassigned codes read as a released high level.
      wire [31:0] src_vec = {7'h7f, sensor_sig, siggen_dig, pwm_lvl, dir_eff};
      assign sel_lvl[n] = src_vec[src_r[n]];

      wire dopm_path_e path = dopm_path_e'(path_r[2*n +: 2]);
      dopm_pin_s pin_nxt;
      assign pin_nxt.mode_switch     = mode_r[n];
      assign pin_nxt.cutoff_switch   = (path == DOPM_PATH_ON);
      // The fast switch alone carries real-time edges, and only on a connected path.
      assign pin_nxt.fast_low_switch = (path == DOPM_PATH_ON) && !sel_lvl[n];
      assign pin_nxt.short_gnd       = (path == DOPM_PATH_GND);
      assign pin_nxt.short_5v        = (path == DOPM_PATH_5V);

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_r[n] <= '0;
        end else begin
          pin_r[n] <= pin_nxt;
        end
      end

      assign chan_rd[n] = (bus_i.addr == A_SRC)  ? 32'(src_r[n]) :
                          (bus_i.addr == A_FREQ) ? freq_r[n] :
                          (bus_i.addr == A_DUTY) ? duty_r[n] : 32'h0000_0000;
    end
  endgenerate

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [`DOPM_DATA_W-1:0] chan_or;
  always_comb begin
    chan_or = '0;
    for (int i = 0; i < NCH; i++) begin
      chan_or = chan_or | chan_rd[i];
    end
  end

  wire [`DOPM_DATA_W-1:0] ctrl_word = 32'(cnt_r) << `DOPM_CTRL_CNT_LSB |
                                      32'(slave_r) << `DOPM_CTRL_SLAVE;
  wire [`DOPM_DATA_W-1:0] stat_word = 32'(pwm_lvl) << `DOPM_ST_PWM_LSB |
                                      32'(sel_lvl) << `DOPM_ST_LVL_LSB |
                                      32'(cnt_eff) << `DOPM_ST_CNT_LSB;
  wire [`DOPM_DATA_W-1:0] rd_word =
    (bus_i.addr == `DOPM_OFS_CTRL)   ? ctrl_word :
    (bus_i.addr == `DOPM_OFS_DIRECT) ? 32'(direct_r) :
    (bus_i.addr == `DOPM_OFS_MODE)   ? 32'(mode_r) :
    (bus_i.addr == `DOPM_OFS_PATH)   ? 32'(path_r) :
    (bus_i.addr == `DOPM_OFS_STATUS) ? stat_word : chan_or;

  // Read data stand for one cycle only and are zero otherwise.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= bus_i.rd ? rd_word : '0;
    end
  end

  assign rdata = rdata_r;
  assign pin_o = pin_r;

endmodule : dopm_top

`default_nettype wire

// >>> testbench/dopm_properties.sv
// Port checker for the digital output, PWM and multiplexer block.
`timescale 1ns/1ns
`default_nettype none
`include "dopm_params.svh"

module dopm_properties (
  // Clock and reset
  input wire logic                                core_clk,
  input wire logic                                rst_n,
  // Watched ports
  input wire dopm_pkg::dopm_bus_s                 bus_i,
  input wire logic [`DOPM_DATA_W-1:0]             rdata,
  input wire logic [`DOPM_NUM_CH-1:0]             siggen_dig,
  input wire logic                                sensor_sig,
  input wire dopm_pkg::dopm_pin_s [`DOPM_NUM_CH-1:0] pin_o
);
  import dopm_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  rdata_idle_a: assert property (!bus_i.rd |=> rdata == '0)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (bus_i.rd && bus_i.addr == 8'hfc |=> rdata == '0)
    else $error("unmapped read not zero");
  direct_back_a: assert property (bus_i.rd && bus_i.addr == `DOPM_OFS_DIRECT &&
      $past(bus_i.wr) && $past(bus_i.addr) == `DOPM_OFS_DIRECT
      |=> rdata == {24'h0, $past(bus_i.wdata[7:0], 2)}) else $error("direct readback wrong");
  count_clamp_a: assert property (bus_i.rd && bus_i.addr == `DOPM_OFS_STATUS &&
      $past(bus_i.wr) && $past(bus_i.addr) == `DOPM_OFS_CTRL && $past(bus_i.wdata[3:0]) == 4'hf
      |=> rdata[19:16] == ($past(bus_i.wdata[4], 2) ? 4'h6 : 4'h8))
    else $error("channel count not clamped");

  // The switch states of each output must never contradict each other, and the mode switch opens only after a mode write.
  for (genvar n = 0; n < `DOPM_NUM_CH; n++) begin : g_pin
    cut_exclusive_a: assert property (pin_o[n].cutoff_switch |->
        !pin_o[n].short_gnd && !pin_o[n].short_5v) else $error("cut-off closed while shorted");
    short_single_a: assert property (!(pin_o[n].short_gnd && pin_o[n].short_5v))
      else $error("both shorts closed");
    fast_cutoff_a: assert property (pin_o[n].fast_low_switch |-> pin_o[n].cutoff_switch)
      else $error("fast switch closed with cut-off open");
    mode_cause_a: assert property ($fell(pin_o[n].mode_switch) |->
        $past(bus_i.wr && bus_i.addr == `DOPM_OFS_MODE, 2)) else $error("mode switch fell alone");
  end
endmodule : dopm_properties

`default_nettype wire

// >>> testbench/dopm_load_model.sv
// Loads and pull-ups hanging on the eight outputs, giving each wire level.
`timescale 1ns/1ns
`default_nettype none
`include "dopm_params.svh"

module dopm_load_model (
  // Clock and board setting
  input wire logic                                core_clk,
  input wire logic                                ext_pull,
  // Switch drives and wire levels
  input wire dopm_pkg::dopm_pin_s [`DOPM_NUM_CH-1:0] pin_o,
  output logic [`DOPM_NUM_CH-1:0]                 level
);
  import dopm_pkg::*;
  // A floating open collector toggles so that no stale level can pass as a match.
  logic float_r = 1'b0;
  always_ff @(posedge core_clk) float_r <= !float_r;
  always_comb begin
    for (int n = 0; n < `DOPM_NUM_CH; n++) begin
      if (pin_o[n].short_gnd) level[n] = 1'b0;
      else if (pin_o[n].short_5v) level[n] = 1'b1;
      else if (pin_o[n].cutoff_switch && pin_o[n].fast_low_switch) level[n] = 1'b0;
      else if (pin_o[n].mode_switch || ext_pull) level[n] = 1'b1;
      else level[n] = float_r;
    end
  end
endmodule : dopm_load_model

`default_nettype wire

// >>> testbench/test_dopm_top.sv
// Self-checking bench for the digital output, PWM and multiplexer block.
`timescale 1ns/1ns
`default_nettype none
`include "dopm_params.svh"

module test_dopm_top;
  import dopm_pkg::*;
  logic            core_clk = 1'b0;
  logic            rst_n    = 1'b0;
  dopm_bus_s       bus      = '0;
  logic [7:0]      siggen   = '0;
  logic            sensor   = 1'b0;
  logic            ext_pull = 1'b0;
  logic [31:0]     rdata;
  dopm_pin_s [7:0] pin_o;
  logic [7:0]      level;
  int              bad_count = 0;
  int              compares  = 0;

  always #2 core_clk = ~core_clk;
  dopm_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .bus_i(bus), .rdata(rdata),
    .siggen_dig(siggen), .sensor_sig(sensor), .pin_o(pin_o));
  dopm_load_model load_u (.core_clk(core_clk), .ext_pull(ext_pull), .pin_o(pin_o),
    .level(level));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic results();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge core_clk);
    bus.wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  // Write, then read another place with no gap, returning the read data.
  task automatic wrd(input logic [7:0] a, input logic [31:0] dw, input logic [7:0] b,
                     output logic [31:0] d);
    bus.addr <= a;
    bus.wdata <= dw;
    bus.wr <= 1'b1;
    @(posedge core_clk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b1;
    bus.addr <= b;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
    @(posedge core_clk);
  endtask : wrd
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
    @(posedge core_clk);
  endtask : rd
  task automatic wait_lvl(input int n, input logic v);
    int i;
    i = 0;
    // Step off the edge so that a pin launched at this edge has settled.
    #1;
    while (level[n] !== v && i < 3000) begin
      step(1);
      i++;
    end
    if (level[n] !== v) begin
      bad_count++;
      $display("ERROR wait level expected %b seen %b", v, level[n]);
      results();
    end
  endtask : wait_lvl

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [31:0] d;
    rd(8'h00, d); chk("ctrl", 32'h8, d);
    rd(8'h04, d); chk("direct", 32'hff, d);
    rd(8'h08, d); chk("mode", 32'hff, d);
    rd(8'h0c, d); chk("path", 0, d);
    rd(8'h40, d); chk("freq", 0, d);
    rd(8'hfc, d); chk("unmapped", 0, d);
    for (int n = 0; n < 8; n++) begin
      rd(8'h20 + 8'(4 * n), d); chk("src", n, d);
    end
    chk("idle level", 8'hff, level);
  endtask : t_regs
  task automatic t_path();
    logic [31:0] d;
    wr(8'h0c, 32'h5555);
    wrd(8'h04, 32'ha4, 8'h04, d); chk("direct back", 32'ha4, d);
    step(3); chk("direct level", 8'ha4, level);
    for (int c = 0; c < 4; c++) begin
      wr(8'h0c, 32'h5554 | c);
      step(3);
      chk("path level", (c == 1 || c == 2) ? 0 : 1, level[0]);
      chk("cutoff", c == 1, pin_o[0].cutoff_switch);
    end
  endtask : t_path
  task automatic t_src();
    wr(8'h0c, 32'h5555);
    wr(8'h20, 32'h13);
    wr(8'h24, 32'h18);
    wr(8'h28, 32'h00);
    for (int v = 0; v < 2; v++) begin
      siggen <= v ? 8'h08 : 8'h00;
      sensor <= 1'(v);
      step(3);
      chk("mux level", {1'b0, 1'(v), 1'(v)}, level[2:0]);
    end
    wr(8'h28, 32'h1f);
    step(3); chk("const src", 1, level[2]);
    wr(8'h0c, 32'h5515);
    wr(8'h08, 32'hf7);
    step(3); chk("mode off", 0, pin_o[3].mode_switch);
    ext_pull <= 1'b1;
    step(1); chk("ext pull", 1, level[3]);
  endtask : t_src
  task automatic t_pwm();
    int hi;
    int hi5;
    wr(8'h30, 32'h08);
    wr(8'h34, 32'h09);
    wr(8'h3c, 32'h0d55);
    wr(8'h44, 32'h4000_0000);
    wr(8'h40, 32'd100000);
    wr(8'h4c, 32'h8000_0000);
    wait_lvl(4, 0);
    wait_lvl(4, 1);
    hi = 0;
    hi5 = 0;
    repeat (2500) begin
      step(1);
      hi += level[4];
      hi5 += level[5];
    end
    chk("pwm half", 1, hi >= 1248 && hi <= 1253);
    chk("pwm idle", 0, hi5);
    wait_lvl(4, 0);
    wait_lvl(4, 1);
    wr(8'h44, 32'h8000_0000);
    #1;
    hi = 2;
    while (level[4] === 1'b1 && hi < 3000) begin
      step(1);
      hi++;
    end
    chk("pwm kept", 1, hi >= 1247 && hi <= 1254);
    step(1300);
    hi = 0;
    repeat (2500) begin
      step(1);
      hi += level[4];
    end
    chk("pwm full", 2500, hi);
  endtask : t_pwm
  task automatic t_count();
    logic [31:0] d;
    wrd(8'h00, 32'h03, 8'h10, d); chk("count", 3, d[19:16]);
    chk("status pwm", 8'h01, d[7:0]);
    wrd(8'h00, 32'h1f, 8'h10, d); chk("slave count", 6, d[19:16]);
    wrd(8'h00, 32'h0f, 8'h10, d); chk("full count", 8, d[19:16]);
  endtask : t_count

  initial begin
    repeat (5) @(posedge core_clk);
    chk("reset pins", '0, pin_o);
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_path();
    t_src();
    t_pwm();
    t_count();
    results();
  end
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule : test_dopm_top

bind dopm_top dopm_properties chk_u (.core_clk(core_clk), .rst_n(rst_n), .bus_i(bus_i),
  .rdata(rdata), .siggen_dig(siggen_dig), .sensor_sig(sensor_sig), .pin_o(pin_o));

`default_nettype wire
